// file: hdl/idu_dispatch.v
`timescale 1ns/10ps
`include "idu_consts.vh"

module idu_dispatch #(
	parameter NSRC = 14
) (
	input  wire            i_clk,
	input  wire            i_rst_b,
	// Core trap conditions, one-cycle pulses at instruction end
	input  wire            i_div_error,
	input  wire            i_instr_done,
	input  wire            i_single_step_flag,
	input  wire            i_overflow_break_op,
	input  wire            i_overflow_flag,
	input  wire            i_break_three_op,
	input  wire            i_bounds_check_op,
	input  wire            i_bounds_fail,
	input  wire            i_coprocessor_escape_op,
	input  wire            i_port_io_op,
	input  wire            i_io_trap_flag,
	input  wire            i_int_enable,
	input  wire            i_nmi,
	input  wire            i_external_vectored_request,
	input  wire [7:0]      i_ext_vector,
	// I/O sources, order: ser err0 rx0 tx0 err1 rx1 tx1, dma0 dma1, ext0..2, tmr0..2
	input  wire [NSRC-1:0] i_io_req,
	input  wire            i_time_base_request,
	input  wire [3*NSRC-1:0] i_io_prio,
	input  wire [2*NSRC-1:0] i_io_mode,
	input  wire [NSRC-1:0] i_search_en,
	input  wire [7:0]      i_search_char,
	// Core state and handshakes
	input  wire [15:0]     i_program_counter,
	input  wire [15:0]     i_status_word,
	input  wire            i_priority_release_op,
	input  wire            i_bank_switch_return_op,
	input  wire [15:0]     i_bank_save_pc,
	input  wire [15:0]     i_bank_save_psw,
	input  wire [2:0]      i_bank_save_prev,
	input  wire            i_ack,
	input  wire [15:0]     i_rdata,
	input  wire [7:0]      i_ms_count,
	input  wire [7:0]      i_ms_byte,
	// Dispatch outputs
	output reg             o_take_vector,
	output reg  [7:0]      o_vector_num,
	output reg  [19:0]     o_vector_addr,
	output reg             o_push_ctx,
	output reg  [15:0]     o_new_pc,
	output reg  [15:0]     o_new_ps,
	output reg             o_load_seg,
	output reg             o_load_pc,
	output reg             o_bank_switch,
	output reg  [2:0]      o_bank,
	output reg  [15:0]     o_save_pc,
	output reg  [15:0]     o_save_psw,
	output reg  [2:0]      o_prev_bank,
	output reg             o_restore,
	output reg  [15:0]     o_restore_psw,
	output reg             o_ms_xfer,
	output reg  [11:0]     o_ms_desc_addr,
	output reg  [7:0]      o_ms_count_nxt,
	output reg             o_ext_inta,
	output reg  [7:0]      o_in_service_priority_reg,
	output reg             o_busy
);

	localparam ST_IDLE  = 4'b0001;
	localparam ST_LO    = 4'b0010;
	localparam ST_HI    = 4'b0100;
	localparam ST_MS    = 4'b1000;

	reg  [3:0]  state_ff;
	reg  [3:0]  nxt_state;
	reg  [NSRC-1:0] pend_ff;
	reg         tb_pend_ff;
	reg  [7:0]  vec_ff;
	reg         bank_ff;
	reg  [3:0]  src_ff;
	reg         is_io_ff;
	reg  [15:0] pc_word_ff;

	// Best I/O candidate by priority, lowest index wins ties
	reg  [3:0]  win_idx;
	reg  [2:0]  win_prio;
	reg         win_ok;
	reg  [1:0]  win_mode;
	reg  [7:0]  win_vec;
	integer     k;
	always @* begin
		win_idx  = 4'h0;
		win_prio = 3'h7;
		win_ok   = 1'b0;
		for (k = 0; k < NSRC; k = k + 1) begin
			if (pend_ff[k] && (!win_ok || i_io_prio[3*k +: 3] < win_prio)) begin
				win_ok   = 1'b1;
				win_idx  = k[3:0];
				win_prio = i_io_prio[3*k +: 3];
			end
		end
		win_mode = i_io_mode[2*win_idx +: 2];
		if (win_idx < 4'd3)
			win_vec = `IDU_VEC_SER0 + {4'h0, win_idx};
		else if (win_idx < 4'd6)
			win_vec = `IDU_VEC_SER1 + {4'h0, win_idx} - 8'h03;
		else if (win_idx < 4'd8)
			win_vec = `IDU_VEC_DMA + {4'h0, win_idx} - 8'h06;
		else if (win_idx < 4'd11)
			win_vec = `IDU_VEC_EXT + {4'h0, win_idx} - 8'h08;
		else
			win_vec = `IDU_VEC_TMR + {4'h0, win_idx} - 8'h0B;
	end

	// Highest in-service level gate: a level may preempt only if strictly higher
	reg  [7:0]  higher_mask;
	reg         io_allowed;
	reg         tb_allowed;
	reg  [7:0]  rel_mask;
	integer     j;
	always @* begin
		higher_mask = 8'h00;
		for (j = 0; j < 8; j = j + 1) begin
			if (j < win_prio)
				higher_mask[j] = 1'b1;
		end
		io_allowed = win_ok && ((o_in_service_priority_reg & (higher_mask | (8'h01 << win_prio))) == 8'h00);
		tb_allowed = tb_pend_ff && (o_in_service_priority_reg == 8'h00);
	end

	// Highest level in service, the one a release clears
	always @* begin
		rel_mask = o_in_service_priority_reg & (~o_in_service_priority_reg + 8'h01);
	end

	// Software trap select, fixed order
	reg         sw_trap;
	reg  [7:0]  sw_vec;
	always @* begin
		sw_trap = 1'b1;
		sw_vec  = `IDU_VEC_DIV;
		if (i_div_error)
			sw_vec = `IDU_VEC_DIV;
		else if (i_overflow_break_op && i_overflow_flag)
			sw_vec = `IDU_VEC_OVF;
		else if (i_bounds_check_op && i_bounds_fail)
			sw_vec = `IDU_VEC_BOUND;
		else if (i_break_three_op)
			sw_vec = `IDU_VEC_BREAK_THREE_OP;
		else if (i_coprocessor_escape_op)
			sw_vec = `IDU_VEC_ESC;
		else if (i_port_io_op && i_io_trap_flag)
			sw_vec = `IDU_VEC_IOTRAP;
		else if (i_instr_done && i_single_step_flag)
			sw_vec = `IDU_VEC_STEP;
		else
			sw_trap = 1'b0;
	end

	// Next state
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (sw_trap || i_nmi || (i_int_enable && (i_external_vectored_request || tb_allowed)))
					nxt_state = ST_LO;
				else if (io_allowed && win_mode == `IDU_MODE_MACRO)
					nxt_state = ST_MS;
				else if (io_allowed && i_int_enable && win_mode != `IDU_MODE_MACRO)
					nxt_state = (win_mode == `IDU_MODE_BANK) ? ST_HI : ST_LO;
			end
			ST_LO: if (i_ack) nxt_state = ST_HI;
			ST_HI: if (i_ack) nxt_state = ST_IDLE;
			ST_MS: if (i_ack) nxt_state = ST_IDLE;
			default: nxt_state = ST_IDLE;
		endcase
	end

	// Request capture and dispatch
	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			state_ff       <= ST_IDLE;
			pend_ff        <= {NSRC{1'b0}};
			tb_pend_ff     <= 1'b0;
			vec_ff         <= 8'h00;
			bank_ff        <= 1'b0;
			src_ff         <= 4'h0;
			is_io_ff       <= 1'b0;
			pc_word_ff     <= 16'h0000;
			o_take_vector  <= 1'b0;
			o_vector_num   <= 8'h00;
			o_vector_addr  <= 20'h00000;
			o_push_ctx     <= 1'b0;
			o_new_pc       <= 16'h0000;
			o_new_ps       <= 16'h0000;
			o_load_seg     <= 1'b0;
			o_load_pc      <= 1'b0;
			o_bank_switch  <= 1'b0;
			o_bank         <= `IDU_BANK_RST;
			o_save_pc      <= 16'h0000;
			o_save_psw     <= 16'h0000;
			o_prev_bank    <= `IDU_BANK_RST;
			o_restore      <= 1'b0;
			o_restore_psw  <= 16'h0000;
			o_ms_xfer      <= 1'b0;
			o_ms_desc_addr <= 12'h000;
			o_ms_count_nxt <= 8'h00;
			o_ext_inta     <= 1'b0;
			o_in_service_priority_reg         <= `IDU_IN_SERVICE_PRIORITY_REG_RST;
			o_busy         <= 1'b0;
		end else begin
			state_ff      <= nxt_state;
			o_busy        <= (nxt_state != ST_IDLE);
			// Pulse outputs idle low unless a state raises them
			o_take_vector <= 1'b0;
			o_push_ctx    <= 1'b0;
			o_load_seg    <= 1'b0;
			o_load_pc     <= 1'b0;
			o_bank_switch <= 1'b0;
			o_restore     <= 1'b0;
			o_ms_xfer     <= 1'b0;
			o_ext_inta    <= 1'b0;
			// Pending sources: new request wins over acceptance clear
			pend_ff    <= pend_ff | i_io_req;
			tb_pend_ff <= tb_pend_ff | i_time_base_request;
			// Release the highest level in service
			if (i_priority_release_op)
				o_in_service_priority_reg <= o_in_service_priority_reg & ~rel_mask;
			// Bank return restores prior context
			if (i_bank_switch_return_op && state_ff == ST_IDLE) begin
				o_restore     <= 1'b1;
				o_bank        <= i_bank_save_prev;
				o_new_pc      <= i_bank_save_pc;
				o_restore_psw <= i_bank_save_psw;
			end
			// Per-state dispatch actions
			case (state_ff)
				ST_IDLE: begin
					is_io_ff <= 1'b0;
					bank_ff  <= 1'b0;
					if (nxt_state == ST_LO || nxt_state == ST_HI || nxt_state == ST_MS) begin
						if (sw_trap)
							vec_ff <= sw_vec;
						else if (i_nmi)
							vec_ff <= `IDU_VEC_NMI;
						else if (i_int_enable && i_external_vectored_request) begin
							vec_ff     <= i_ext_vector;
							o_ext_inta <= 1'b1;
						end else if (i_int_enable && tb_allowed) begin
							vec_ff     <= `IDU_VEC_TB;
							tb_pend_ff <= i_time_base_request;
							o_in_service_priority_reg[`IDU_TB_PRIO] <= 1'b1;
						end else begin
							vec_ff   <= win_vec;
							bank_ff  <= (win_mode == `IDU_MODE_BANK);
							src_ff   <= win_idx;
							is_io_ff <= 1'b1;
							pend_ff[win_idx] <= i_io_req[win_idx];
							if (win_mode != `IDU_MODE_MACRO)
								o_in_service_priority_reg[win_prio] <= 1'b1;
						end
						if (nxt_state == ST_HI) begin
							o_bank_switch <= 1'b1;
							o_prev_bank   <= o_bank;
							o_bank        <= win_prio;
							o_save_pc     <= i_program_counter;
							o_save_psw    <= i_status_word;
						end else if (nxt_state == ST_LO) begin
							o_push_ctx <= 1'b1;
							o_save_pc  <= i_program_counter;
							o_save_psw <= i_status_word;
						end else if (nxt_state == ST_MS) begin
							o_ms_xfer      <= 1'b1;
							o_ms_desc_addr <= `IDU_MS_BASE + {5'h00, win_idx[2:0], 3'h0};
						end
					end
				end
				ST_LO: begin
					o_take_vector <= 1'b1;
					o_vector_num  <= vec_ff;
					o_vector_addr <= {10'h000, vec_ff, 2'b00};
					if (i_ack)
						pc_word_ff <= {i_rdata[7:0], i_rdata[15:8]};
				end
				ST_HI: begin
					if (i_ack) begin
						o_load_pc <= 1'b1;
						// Bank switch takes the routine address as read, no segment load
						if (bank_ff)
							o_new_pc <= i_rdata;
						else begin
							o_load_seg <= 1'b1;
							o_new_pc   <= pc_word_ff;
							o_new_ps   <= {i_rdata[7:0], i_rdata[15:8]};
						end
					end else begin
						o_take_vector <= ~bank_ff;
						o_vector_num  <= vec_ff;
						o_vector_addr <= {10'h000, vec_ff, 2'b10};
					end
				end
				ST_MS: begin
					if (i_ack) begin
						o_ms_count_nxt <= i_ms_count - 8'h01;
						// Terminal count or search hit re-pends the source
						if (i_ms_count == 8'h01 || (i_search_en[src_ff] && i_ms_byte == i_search_char))
							pend_ff[src_ff] <= 1'b1;
					end
				end
				default: ;
			endcase
		end
	end
endmodule

// file: inc/idu_consts.vh
`ifndef IDU_CONSTS_VH
`define IDU_CONSTS_VH
// Fixed vector numbers
`define IDU_VEC_DIV        8'h00
`define IDU_VEC_STEP       8'h01
`define IDU_VEC_NMI        8'h02
`define IDU_VEC_BREAK_THREE_OP       8'h03
`define IDU_VEC_OVF        8'h04
`define IDU_VEC_BOUND      8'h05
`define IDU_VEC_ESC        8'h07
`define IDU_VEC_IOTRAP     8'h14
`define IDU_VEC_SER0       8'h1C
`define IDU_VEC_SER1       8'h20
`define IDU_VEC_DMA        8'h24
`define IDU_VEC_EXT        8'h28
`define IDU_VEC_TMR        8'h2C
`define IDU_VEC_TB         8'h2F
// Time base priority level
`define IDU_TB_PRIO        3'h7
// Service modes
`define IDU_MODE_VEC       2'h0
`define IDU_MODE_BANK      2'h1
`define IDU_MODE_MACRO     2'h2
// Macro service descriptor window, low 12 address bits
`define IDU_MS_BASE        12'hE00
`define IDU_MS_DESC_SHIFT  3
// Reset values
`define IDU_IN_SERVICE_PRIORITY_REG_RST       8'h00
`define IDU_BANK_RST       3'h0
`endif

// file: tb/idu_dispatch_assertions.sv
`timescale 1ns/10ps
module idu_dispatch_assertions (
	input wire        i_clk,
	input wire        i_rst_b,
	input wire        i_div_error,
	input wire        i_int_enable,
	input wire        i_priority_release_op,
	input wire        o_take_vector,
	input wire [7:0]  o_vector_num,
	input wire [19:0] o_vector_addr,
	input wire        o_push_ctx,
	input wire        o_load_pc,
	input wire        o_load_seg,
	input wire        o_bank_switch,
	input wire [2:0]  o_bank,
	input wire        o_ms_xfer,
	input wire [11:0] o_ms_desc_addr,
	input wire        o_ext_inta,
	input wire [7:0]  o_in_service_priority_reg,
	input wire        o_busy
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	property p_vec_addr;
		o_take_vector |-> o_vector_addr[19:10] == 10'h000 && o_vector_addr[9:2] == o_vector_num && !o_vector_addr[0];
	endproperty
	a_vec_addr: assert property (p_vec_addr) else $error("vector address off table");
	property p_div;
		i_div_error && !o_busy |-> ##[1:3] (o_take_vector && o_vector_num == 8'h00);
	endproperty
	a_div: assert property (p_div) else $error("divide trap vector wrong");
	property p_bank_in_service_priority_reg;
		o_bank_switch |-> ##[0:1] o_in_service_priority_reg[o_bank];
	endproperty
	a_bank_in_service_priority_reg: assert property (p_bank_in_service_priority_reg) else $error("bank level not in service");
	property p_release;
		i_priority_release_op && o_in_service_priority_reg == 8'h01 && !o_busy |-> ##[1:2] o_in_service_priority_reg == 8'h00;
	endproperty
	a_release: assert property (p_release) else $error("level not released");
	property p_push_load;
		o_push_ctx |-> ##[1:40] o_load_seg;
	endproperty
	a_push_load: assert property (p_push_load) else $error("push without branch");
	property p_ms_desc;
		o_ms_xfer |-> !o_push_ctx && o_ms_desc_addr[11:6] == 6'h38 && o_ms_desc_addr[2:0] == 3'h0;
	endproperty
	a_ms_desc: assert property (p_ms_desc) else $error("descriptor address wrong");
	property p_ext_en;
		o_ext_inta |-> i_int_enable || $past(i_int_enable);
	endproperty
	a_ext_en: assert property (p_ext_en) else $error("masked request acknowledged");
	property p_seg_pair;
		o_load_seg |-> o_load_pc;
	endproperty
	a_seg_pair: assert property (p_seg_pair) else $error("segment loaded alone");
endmodule
bind idu_dispatch idu_dispatch_assertions u_chk (
	.i_clk(i_clk), .i_rst_b(i_rst_b), .i_div_error(i_div_error), .i_int_enable(i_int_enable),
	.i_priority_release_op(i_priority_release_op), .o_take_vector(o_take_vector), .o_vector_num(o_vector_num),
	.o_vector_addr(o_vector_addr), .o_push_ctx(o_push_ctx), .o_load_pc(o_load_pc), .o_load_seg(o_load_seg),
	.o_bank_switch(o_bank_switch), .o_bank(o_bank), .o_ms_xfer(o_ms_xfer), .o_ms_desc_addr(o_ms_desc_addr),
	.o_ext_inta(o_ext_inta), .o_in_service_priority_reg(o_in_service_priority_reg), .o_busy(o_busy));

// file: tb/idu_core_model.sv
`timescale 1ns/10ps
module idu_core_model #(
	parameter DLY = 2
) (
	input  wire        i_clk,
	input  wire        i_take,
	input  wire        i_step,
	input  wire [19:0] i_addr,
	output reg         o_ack = 1'b0,
	output reg  [15:0] o_rdata = 16'h0000
);
	reg       pend = 1'b0;
	reg [3:0] cnt = 4'h0;
	// Answer each step after DLY cycles; data turns over once released
	always @(negedge i_clk) begin
		if (o_ack) begin
			o_ack <= 1'b0;
			o_rdata <= ~o_rdata;
			cnt <= 4'h0;
		end else if (i_take | pend) begin
			if (cnt == DLY) begin
				o_ack <= 1'b1;
				o_rdata <= {i_addr[7:0] ^ 8'h3C, i_addr[7:0]};
			end else
				cnt <= cnt + 4'h1;
		end
		pend <= (pend | i_step) & ~o_ack;
	end
endmodule

// file: tb/idu_dispatch_tb_top.sv
`timescale 1ns/10ps
module idu_dispatch_tb_top;
	reg         i_clk, i_rst_b, i_div_error, i_instr_done, i_single_step_flag, i_overflow_break_op;
	reg         i_overflow_flag, i_break_three_op, i_bounds_check_op, i_bounds_fail, i_coprocessor_escape_op;
	reg         i_port_io_op, i_io_trap_flag, i_int_enable, i_nmi, i_external_vectored_request;
	reg         i_time_base_request, i_priority_release_op, i_bank_switch_return_op;
	reg  [7:0]  i_ext_vector, i_search_char, i_ms_count, i_ms_byte, n;
	reg  [13:0] i_io_req, i_search_en;
	reg  [41:0] i_io_prio;
	reg  [27:0] i_io_mode;
	reg  [15:0] i_program_counter, i_status_word, i_bank_save_pc, i_bank_save_psw;
	reg  [2:0]  i_bank_save_prev;
	wire        i_ack, o_take_vector, o_push_ctx, o_load_seg, o_load_pc, o_bank_switch, o_restore;
	wire        o_ms_xfer, o_ext_inta, o_busy;
	wire [7:0]  o_vector_num, o_ms_count_nxt, o_in_service_priority_reg;
	wire [19:0] o_vector_addr;
	wire [15:0] i_rdata, o_new_pc, o_new_ps, o_save_pc, o_save_psw, o_restore_psw;
	wire [2:0]  o_bank, o_prev_bank;
	wire [11:0] o_ms_desc_addr;
	wire [4:0]  evt = {o_load_pc, o_restore, o_bank_switch, o_ms_xfer, o_push_ctx};
	integer     error_cnt, cmp_count, pushes, k;

	idu_dispatch uut (.*);
	idu_core_model u_core (.i_clk(i_clk), .i_take(o_take_vector), .i_step(o_bank_switch | o_ms_xfer),
		.i_addr(o_vector_addr), .o_ack(i_ack), .o_rdata(i_rdata));

	// Clock and vectored entry count
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) if (o_push_ctx === 1'b1) pushes = pushes + 1;

	task report_and_stop;
		begin
			if (error_cnt == 0 && cmp_count > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	task chk(input [19:0] seen, input [19:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (seen !== exp) begin
				error_cnt = error_cnt + 1;
				$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task wait_evt(input integer e);
		integer i;
		begin
			i = 0;
			while (evt[e] !== 1'b1 && i < 80) begin
				@(negedge i_clk);
				i = i + 1;
			end
			chk(evt[e], 1'b1);
		end
	endtask
	task expect_vec(input [7:0] v);
		reg [7:0] a;
		begin
			a = {v[5:0], 2'b00};
			wait_evt(0);
			wait_evt(4);
			chk(o_vector_num, v);
			chk(o_new_pc, {a, a ^ 8'h3C});
			chk(o_new_ps, {a | 8'h02, (a | 8'h02) ^ 8'h3C});
			repeat (3) @(negedge i_clk);
		end
	endtask
	task release_chk(input [7:0] lvl);
		begin
			chk(o_in_service_priority_reg, lvl);
			i_priority_release_op = 1'b1;
			@(negedge i_clk);
			i_priority_release_op = 1'b0;
			@(negedge i_clk);
		end
	endtask
	task io_pulse(input [13:0] m);
		begin
			i_io_req = m;
			@(negedge i_clk);
			i_io_req = 14'h0000;
		end
	endtask

	// Hang guard
	initial begin
		#(25 * 20000);
		error_cnt = error_cnt + 1;
		report_and_stop;
	end

	// Main sequence
	initial begin
		{i_rst_b, i_div_error, i_instr_done, i_single_step_flag, i_overflow_break_op, i_overflow_flag,
			i_break_three_op, i_bounds_check_op, i_bounds_fail, i_coprocessor_escape_op, i_port_io_op,
			i_io_trap_flag, i_int_enable, i_nmi, i_external_vectored_request, i_time_base_request,
			i_priority_release_op, i_bank_switch_return_op, i_io_req, i_search_en, i_io_mode, i_io_prio} = 0;
		{i_ext_vector, i_search_char, i_ms_count, i_ms_byte} = 32'h305A0500;
		{i_program_counter, i_status_word, i_bank_save_pc, i_bank_save_psw} = 64'h1357F20224680A0B;
		i_bank_save_prev = 3'h3;
		{error_cnt, cmp_count, pushes} = 0;
		repeat (20) @(negedge i_clk);
		i_rst_b = 1'b1;
		i_int_enable = 1'b1;
		// Each trap source alone
		for (k = 0; k < 9; k = k + 1) begin
			case (k)
				0: {i_div_error, n} = {1'b1, 8'h00};
				1: {i_instr_done, i_single_step_flag, n} = {2'b11, 8'h01};
				2: {i_nmi, n} = {1'b1, 8'h02};
				3: {i_break_three_op, n} = {1'b1, 8'h03};
				4: {i_overflow_break_op, i_overflow_flag, n} = {2'b11, 8'h04};
				5: {i_bounds_check_op, i_bounds_fail, n} = {2'b11, 8'h05};
				6: {i_coprocessor_escape_op, n} = {1'b1, 8'h07};
				7: {i_port_io_op, i_io_trap_flag, n} = {2'b11, 8'h14};
				default: {i_external_vectored_request, n} = {1'b1, 8'h30};
			endcase
			@(negedge i_clk);
			{i_div_error, i_instr_done, i_single_step_flag, i_nmi, i_break_three_op, i_overflow_break_op,
				i_overflow_flag, i_bounds_check_op, i_bounds_fail, i_coprocessor_escape_op, i_port_io_op,
				i_io_trap_flag, i_external_vectored_request} = 13'h0000;
			expect_vec(n);
		end
		// Every I/O source alone at level index mod 8
		for (k = 0; k < 14; k = k + 1)
			i_io_prio[3 * k +: 3] = k[2:0];
		for (k = 0; k < 14; k = k + 1) begin
			n = 28 + k + (k > 2) + (k > 5) + 2 * (k > 7) + (k > 10);
			io_pulse(14'h0001 << k);
			expect_vec(n);
			release_chk(8'h01 << k[2:0]);
			chk(o_in_service_priority_reg, 8'h00);
		end
		// Masked pair at one level, tie order, then hold at same level
		i_io_prio = {14{3'h4}};
		i_int_enable = 1'b0;
		k = pushes;
		io_pulse(14'h0600);
		repeat (20) @(negedge i_clk);
		chk(pushes, k);
		i_int_enable = 1'b1;
		expect_vec(8'd41);
		k = pushes;
		repeat (20) @(negedge i_clk);
		chk(pushes, k);
		release_chk(8'h10);
		expect_vec(8'd42);
		release_chk(8'h10);
		// Bank switch at level 5, then return
		i_io_prio = {14{3'h5}};
		i_io_mode[5:4] = 2'h1;
		io_pulse(14'h0004);
		wait_evt(2);
		chk(o_bank, 3'h5);
		chk(o_save_pc, i_program_counter);
		chk(o_save_psw, i_status_word);
		chk(o_prev_bank, 3'h0);
		wait_evt(4);
		release_chk(8'h20);
		i_bank_switch_return_op = 1'b1;
		@(negedge i_clk);
		i_bank_switch_return_op = 1'b0;
		wait_evt(3);
		chk(o_restore_psw, i_bank_save_psw);
		chk(o_bank, i_bank_save_prev);
		chk(o_new_pc, i_bank_save_pc);
		// Macro service, plain then with search hit
		i_io_mode[7:6] = 2'h2;
		k = pushes;
		io_pulse(14'h0008);
		wait_evt(1);
		chk(o_ms_desc_addr, 12'hE18);
		repeat (6) @(negedge i_clk);
		chk(o_ms_count_nxt, 8'h04);
		chk(pushes, k);
		{i_search_en[3], i_ms_byte} = {1'b1, 8'h5A};
		io_pulse(14'h0008);
		wait_evt(1);
		i_io_mode[7:6] = 2'h0;
		expect_vec(8'd32);
		release_chk(8'h20);
		// Time base request
		i_time_base_request = 1'b1;
		@(negedge i_clk);
		i_time_base_request = 1'b0;
		expect_vec(8'h2F);
		release_chk(8'h80);
		report_and_stop;
	end
endmodule
